// >>> common/tic_defs.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TIC_DEFS_SVH
`define TIC_DEFS_SVH

`define TIC_ADDR_CTRL      8'hA1
`define TIC_ADDR_HTH       8'hA2
`define TIC_ADDR_SEC       8'hA3
`define TIC_ADDR_MIN       8'hA4
`define TIC_ADDR_HOUR      8'hA5
`define TIC_ADDR_MATCH     8'hA6

`define TIC_CTRL_RESET     8'h00
`define TIC_BIT_CLKEN      0
`define TIC_BIT_CNTEN      1
`define TIC_BIT_FLAG       2
`define TIC_BIT_SINGLE     3
`define TIC_BIT_TB_LO      4
`define TIC_BIT_TB_HI      5
`define TIC_BIT_DAYWRAP    6

`define TIC_XTAL_PER_TICK  8'hFF
`define TIC_HTH_MAX        8'h7F
`define TIC_SEC_MAX        8'h3B
`define TIC_MIN_MAX        8'h3B
`define TIC_HOUR_MAX_DAY   8'h17
`define TIC_HOUR_MAX_FULL  8'hFF
`define TIC_WAKE_VECTOR    16'h0053

`endif

// >>> common/tic_pkg.sv
// Types shared by the long interval timer modules.
package tic_pkg;

   typedef enum logic [1:0] {
      TB_TICK = 2'h0,
      TB_SEC  = 2'h1,
      TB_MIN  = 2'h2,
      TB_HOUR = 2'h3
   } tic_timebase_t;

   typedef struct packed {
      logic          day_hour_wrap_select;
      tic_timebase_t timebase_select;
      logic          single_shot_select;
      logic          interval_elapsed_flag;
      logic          interval_count_enable;
      logic          timekeeping_clock_enable;
   } tic_ctrl_t;

   typedef struct packed {
      logic [7:0] hour;
      logic [7:0] min;
      logic [7:0] sec;
      logic [7:0] hth;
   } tic_time_t;

endpackage : tic_pkg

// >>> design/tic_timebase.sv
// Crystal divider and time-keeping counters of the long interval timer.
`timescale 1ns/1ps
`include "tic_defs.svh"

module tic_timebase (
   // Clock and power-on clear
   input  wire logic              clk,
   input  wire logic              por,
   // Crystal pin and control
   input  wire logic              xtal,
   input  wire logic              run,
   input  wire logic              day_wrap,
   // Software preload
   input  wire logic [3:0]        wr_en,
   input  wire logic [7:0]        wdata,
   // Time and overflow events
   output tic_pkg::tic_time_t     time_now,
   output logic [3:0]             ovf
);

   // ************************************************************
   // Crystal edge detection and 1/128 second tick
   // ************************************************************
   logic       sync1;
   logic       sync2;
   logic       sync3;
   logic [7:0] div;
   logic [7:0] next_div;
   logic       tick;

   // The crystal is asynchronous; only sync2 onward feeds logic.
   always_ff @(posedge clk) begin
      sync1 <= xtal;
      sync2 <= sync1;
      sync3 <= sync2;
   end

   always_comb begin
      next_div = div;
      tick     = 1'b0;
      if (sync2 && !sync3) begin
         next_div = div + 8'h01;
         tick     = (div == `TIC_XTAL_PER_TICK);
      end
   end

   always_ff @(posedge clk) begin
      if (por) begin
         div <= 8'h00;
      end else begin
         div <= next_div;
      end
   end

   // ************************************************************
   // Time registers, one counter per field
   // ************************************************************
   logic [7:0]         lim [4];
   logic [3:0]         carry;
   tic_pkg::tic_time_t next_time;
   logic [7:0]         cur  [4];
   logic [7:0]         nxt  [4];

   assign lim[0] = `TIC_HTH_MAX;
   assign lim[1] = `TIC_SEC_MAX;
   assign lim[2] = `TIC_MIN_MAX;
   assign lim[3] = day_wrap ? `TIC_HOUR_MAX_DAY : `TIC_HOUR_MAX_FULL;
   assign cur[0] = time_now.hth;
   assign cur[1] = time_now.sec;
   assign cur[2] = time_now.min;
   assign cur[3] = time_now.hour;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_field
         logic adv;
         if (g == 0) begin : g_first
            assign adv = tick && run;
         end else begin : g_rest
            assign adv = carry[g-1];
         end
         assign carry[g] = adv && (cur[g] >= lim[g]);
         // A software preload wins over a tick in the same cycle.
         assign nxt[g] = wr_en[g] ? wdata :
                         carry[g] ? 8'h00 :
                         adv ? cur[g] + 8'h01 : cur[g];
      end
   endgenerate

   always_comb begin
      next_time.hth  = nxt[0];
      next_time.sec  = nxt[1];
      next_time.min  = nxt[2];
      next_time.hour = nxt[3];
   end

   always_ff @(posedge clk) begin
      if (por) begin
         time_now <= '0;
         ovf      <= 4'h0;
      end else begin
         time_now <= next_time;
         // ovf[0] is the 1/128 s step itself; ovf[n] is field n-1 wrapping.
         ovf      <= {carry[2:0], tick && run};
      end
   end

endmodule : tic_timebase

// >>> design/tic_long_interval_timer.sv
// Long interval timer: control register, interval counter and wake logic.
`timescale 1ns/1ps
`include "tic_defs.svh"

module tic_long_interval_timer (
   // Clock and resets
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        POR,
   // Crystal pin
   input  wire logic        XTAL_32K,
   // Special function register port
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic [7:0]  SFR_WDATA,
   input  wire logic        SFR_WR,
   output logic      [7:0]  SFR_RDATA,
   // Core interface
   input  wire logic        IRQ_ENABLE,
   input  wire logic        POWER_DOWN,
   output logic             IRQ,
   output logic             WAKE,
   output logic      [15:0] WAKE_VECTOR
);

   // ************************************************************
   // Register decode
   // ************************************************************
   logic                    wr_ctrl;
   logic                    wr_match;
   logic [3:0]              wr_time;
   tic_pkg::tic_ctrl_t      ctrl;
   tic_pkg::tic_ctrl_t      next_ctrl;
   tic_pkg::tic_ctrl_t      wr_val;
   tic_pkg::tic_time_t      time_now;
   logic [3:0]              ovf;
   logic [7:0]              match;
   logic [7:0]              next_match;
   logic [7:0]              icount;
   logic [7:0]              next_icount;
   logic                    step;
   logic                    hit;
   logic [7:0]              next_rdata;
   logic                    next_irq;
   logic                    next_wake;
   logic [15:0]             next_vector;

   // Power-on value of the control register; bit 7 has no storage.
   localparam logic [7:0]   ctrl_reset = `TIC_CTRL_RESET;

   assign wr_ctrl    = SFR_WR && (SFR_ADDR == `TIC_ADDR_CTRL);
   assign wr_match   = SFR_WR && (SFR_ADDR == `TIC_ADDR_MATCH);
   assign wr_time[0] = SFR_WR && (SFR_ADDR == `TIC_ADDR_HTH);
   assign wr_time[1] = SFR_WR && (SFR_ADDR == `TIC_ADDR_SEC);
   assign wr_time[2] = SFR_WR && (SFR_ADDR == `TIC_ADDR_MIN);
   assign wr_time[3] = SFR_WR && (SFR_ADDR == `TIC_ADDR_HOUR);
   assign wr_val     = tic_pkg::tic_ctrl_t'(SFR_WDATA[6:0]);

   // ************************************************************
   // Time base, run from the crystal edges
   // ************************************************************
   // The time registers keep running through RST so that a core reset
   // does not lose the time of day; only POR clears them.
   tic_timebase u_timebase (
      .clk      (CLK),
      .por      (POR),
      .xtal     (XTAL_32K),
      .run      (ctrl.timekeeping_clock_enable),
      .day_wrap (ctrl.day_hour_wrap_select),
      .wr_en    (wr_time),
      .wdata    (SFR_WDATA),
      .time_now (time_now),
      .ovf      (ovf)
   );

   // ************************************************************
   // Interval value register
   // ************************************************************
   // Only a power-on clear empties the interval value, so a core reset
   // leaves a programmed interval in place.
   always_comb begin
      next_match = match;
      if (wr_match) begin
         next_match = SFR_WDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (POR) begin
         match <= 8'h00;
      end else begin
         match <= next_match;
      end
   end

   // ************************************************************
   // Interval counter
   // ************************************************************
   // Match one step early so the flag and the reload land together;
   // the counter never has to hold the match value for a cycle.
   always_comb begin
      step        = ctrl.interval_count_enable
                    && ovf[ctrl.timebase_select];
      hit         = step && (icount + 8'h01 == match);
      next_icount = icount;
      // A cleared enable holds the count at zero, so enabling again
      // always starts a full interval.
      if (!ctrl.interval_count_enable) begin
         next_icount = 8'h00;
      end else if (hit) begin
         next_icount = 8'h00;
      end else if (step) begin
         next_icount = icount + 8'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (POR) begin
         icount <= 8'h00;
      end else begin
         icount <= next_icount;
      end
   end

   // ************************************************************
   // Control register
   // ************************************************************
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = wr_val;
      end
      if (RST) begin
         // A core reset falls back to full-range hours while the time
         // and the interval keep running.
         next_ctrl.day_hour_wrap_select = 1'b0;
      end
      if (hit) begin
         // Hardware set beats a software clear in the same cycle.
         next_ctrl.interval_elapsed_flag = 1'b1;
         if (ctrl.single_shot_select) begin
            next_ctrl.interval_count_enable = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (POR) begin
         ctrl <= tic_pkg::tic_ctrl_t'(ctrl_reset[6:0]);
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   // The read is registered: SFR_RDATA shows the register addressed in
   // the previous cycle, and unmapped addresses read as zero.
   always_comb begin
      case (SFR_ADDR)
         `TIC_ADDR_CTRL:  next_rdata = {1'b0, ctrl};
         `TIC_ADDR_HTH:   next_rdata = time_now.hth;
         `TIC_ADDR_SEC:   next_rdata = time_now.sec;
         `TIC_ADDR_MIN:   next_rdata = time_now.min;
         `TIC_ADDR_HOUR:  next_rdata = time_now.hour;
         `TIC_ADDR_MATCH: next_rdata = match;
         default:         next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST || POR) begin
         SFR_RDATA <= 8'h00;
      end else begin
         SFR_RDATA <= next_rdata;
      end
   end

   // ************************************************************
   // Interrupt and wake
   // ************************************************************
   // The wake vector is the fixed TIC_WAKE_VECTOR, driven below; this block only raises the request
   // and, while the core is powered down, the wake line.
   always_comb begin
      next_irq  = ctrl.interval_elapsed_flag && IRQ_ENABLE;
      next_wake = next_irq && POWER_DOWN;
   end

   always_ff @(posedge CLK) begin
      if (RST || POR) begin
         IRQ  <= 1'b0;
         WAKE <= 1'b0;
      end else begin
         IRQ  <= next_irq;
         WAKE <= next_wake;
      end
   end

   // ************************************************************
   // Wake vector
   // ************************************************************
   always_comb begin
      next_vector = `TIC_WAKE_VECTOR;
   end

   always_ff @(posedge CLK) begin
      if (RST || POR) begin
         WAKE_VECTOR <= `TIC_WAKE_VECTOR;
      end else begin
         WAKE_VECTOR <= next_vector;
      end
   end

endmodule : tic_long_interval_timer

// >>> test/tic_asserts.sv
// Port-level assertions for the long interval timer.
`timescale 1ns/1ps
module tic_asserts (
   // Clock and resets
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        POR,
   // Register port and core side
   input wire logic [7:0]  SFR_ADDR,
   input wire logic [7:0]  SFR_WDATA,
   input wire logic        SFR_WR,
   input wire logic [7:0]  SFR_RDATA,
   input wire logic        IRQ_ENABLE,
   input wire logic        POWER_DOWN,
   input wire logic        IRQ,
   input wire logic        WAKE,
   input wire logic [15:0] WAKE_VECTOR
);
   // *****
   // Checks
   // *****
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST || POR);
   chk_vector_fixed: assert property (
      WAKE_VECTOR == 16'h0053) else $error("bad vector");
   chk_wake_cause: assert property (
      WAKE == (IRQ && $past(POWER_DOWN))) else $error("bad wake");
   chk_irq_flag: assert property (
      $past(SFR_ADDR) == 8'hA1 |->
      IRQ == (SFR_RDATA[2] && $past(IRQ_ENABLE))) else $error("bad irq");
   chk_ctrl_top: assert property (
      $past(SFR_ADDR) == 8'hA1 |-> !SFR_RDATA[7]) else $error("bit7 set");
   chk_unmapped_zero: assert property (
      $past(SFR_ADDR) < 8'hA1 || $past(SFR_ADDR) > 8'hA6 |->
      SFR_RDATA == 8'h00) else $error("unmapped read");
   chk_tick_range: assert property (
      $past(SFR_ADDR) == 8'hA2 |-> SFR_RDATA <= 8'h7F) else $error("tick");
   chk_sec_range: assert property (
      $past(SFR_ADDR) == 8'hA3 |-> SFR_RDATA <= 8'h3B) else $error("sec");
   chk_min_range: assert property (
      $past(SFR_ADDR) == 8'hA4 |-> SFR_RDATA <= 8'h3B) else $error("min");
   chk_match_store: assert property (
      SFR_WR && SFR_ADDR == 8'hA6 ##1 SFR_ADDR == 8'hA6 |=>
      SFR_RDATA == $past(SFR_WDATA, 2)) else $error("match store");
endmodule : tic_asserts

// >>> test/tb_top.sv
// Self-checking bench for the long interval timer.
`timescale 1ns/1ps
module tb_top;
   logic        CLK, RST, POR, XTAL_32K, SFR_WR, IRQ_ENABLE, POWER_DOWN;
   logic [7:0]  SFR_ADDR, SFR_WDATA, SFR_RDATA;
   logic        IRQ, WAKE;
   logic [15:0] WAKE_VECTOR;
   int          miscompares = 0;
   int          checks = 0;
   tic_long_interval_timer DUT (.CLK(CLK), .RST(RST), .POR(POR),
      .XTAL_32K(XTAL_32K), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
      .SFR_WR(SFR_WR), .SFR_RDATA(SFR_RDATA), .IRQ_ENABLE(IRQ_ENABLE),
      .POWER_DOWN(POWER_DOWN), .IRQ(IRQ), .WAKE(WAKE),
      .WAKE_VECTOR(WAKE_VECTOR));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // *****
   // Tasks
   // *****
   task conclude;
      if (miscompares == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge CLK);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      @(negedge CLK);
      SFR_WR = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge CLK);
      SFR_ADDR = a;
      @(negedge CLK);
      cmp({8'h00, SFR_RDATA}, {8'h00, e});
   endtask : rd
   // One call is 256 rising crystal edges, a single 1/128 s step.
   task tick;
      repeat (256) begin
         XTAL_32K = 1'b1;
         repeat (2) @(negedge CLK);
         XTAL_32K = 1'b0;
         repeat (2) @(negedge CLK);
      end
      repeat (6) @(negedge CLK);
   endtask : tick
   task wflag;
      int i;
      SFR_ADDR = 8'hA1;
      for (i = 0; i < 40 && SFR_RDATA[2] !== 1'b1; i++) @(negedge CLK);
      if (i == 40) begin
         miscompares++;
         conclude;
      end
   endtask : wflag
   // Time one step short of carrying into the hour register.
   task pre(input logic [7:0] h);
      wr(8'hA5, h);
      wr(8'hA4, 8'h3B);
      wr(8'hA3, 8'h3B);
      wr(8'hA2, 8'h7F);
   endtask : pre
   initial begin
      repeat (100000) @(posedge CLK);
      miscompares++;
      conclude;
   end
   // *****
   // Sequence
   // *****
   initial begin
      {XTAL_32K, SFR_WR, SFR_ADDR, SFR_WDATA} = '0;
      {IRQ_ENABLE, POWER_DOWN, RST, POR} = 4'hF;
      repeat (20) @(negedge CLK);
      {RST, POR} = 2'h0;
      rd(8'hA1, 8'h00);
      rd(8'hA0, 8'h00);
      rd(8'hA7, 8'h00);
      cmp(WAKE_VECTOR, 16'h0053);
      wr(8'hA2, 8'h10);
      tick;
      rd(8'hA2, 8'h10);
      wr(8'hA1, 8'hF3);
      rd(8'hA1, 8'h73);
      wr(8'hA6, 8'h02);
      rd(8'hA6, 8'h02);
      wr(8'hA1, 8'h0B);
      tick;
      rd(8'hA1, 8'h0B);
      tick;
      wflag;
      rd(8'hA1, 8'h0D);
      cmp({15'h0000, IRQ}, 16'h0001);
      cmp({15'h0000, WAKE}, 16'h0001);
      POWER_DOWN = 1'b0;
      wr(8'hA6, 8'h01);
      wr(8'hA1, 8'h03);
      rd(8'hA1, 8'h03);
      cmp({15'h0000, IRQ}, 16'h0000);
      repeat (2) begin
         tick;
         wflag;
         rd(8'hA1, 8'h07);
         cmp({15'h0000, WAKE}, 16'h0000);
         wr(8'hA1, 8'h03);
      end
      IRQ_ENABLE = 1'b0;
      for (int tb = 1; tb < 4; tb++) begin
         pre(8'h00);
         wr(8'hA1, {2'h0, tb[1:0], 4'h3});
         tick;
         wflag;
         rd(8'hA1, {2'h0, tb[1:0], 4'h7});
         cmp({15'h0000, IRQ}, 16'h0000);
      end
      pre(8'h17);
      wr(8'hA1, 8'h41);
      tick;
      rd(8'hA5, 8'h00);
      RST = 1'b1;
      repeat (20) @(negedge CLK);
      RST = 1'b0;
      rd(8'hA1, 8'h01);
      rd(8'hA5, 8'h00);
      pre(8'h17);
      tick;
      rd(8'hA5, 8'h18);
      conclude;
   end
endmodule : tb_top
bind tic_long_interval_timer tic_asserts u_chk (.CLK(CLK), .RST(RST),
   .POR(POR), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
   .SFR_WR(SFR_WR), .SFR_RDATA(SFR_RDATA), .IRQ_ENABLE(IRQ_ENABLE),
   .POWER_DOWN(POWER_DOWN), .IRQ(IRQ), .WAKE(WAKE),
   .WAKE_VECTOR(WAKE_VECTOR));
